//--- supply_ctrl.sv
// command-driven output, limit, protection and sequence control
`timescale 1ns/1ns
module supply_ctrl
    import supply_ctrl_pkg::*;
#(
    parameter int DELAY_STEP_CYCLES = STEP_CYCLES
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // measured output and fault detection
    input  wire logic [15:0] MEAS_CURRENT,
    input  wire logic        OV_DETECT,
    // sequencer handshake
    input  wire logic        SEQ_DONE,
    output logic             SEQ_RUN,
    output logic      [5:0]  SEQ_START_LOC,
    output logic             KEYPAD_LOCK,
    // applied output
    output logic             OUTPUT_ENABLE,
    output logic      [15:0] APPLIED_VOLT,
    output logic      [15:0] APPLIED_CURR
);

    // ********************************************************
    // state
    // ********************************************************
    logic        output_on;
    logic [15:0] volt_set;
    logic [15:0] curr_set;
    logic [15:0] pending_current_value;
    logic [15:0] current_ceiling;
    logic [15:0] overcurrent_threshold;
    logic [8:0]  protection_trip_delay;
    logic [5:0]  sequence_start_location;
    logic        sequence_run_control;
    logic        oc_tripped;
    logic        ov_tripped;
    logic        cmd_warn;
    logic [15:0] error_code;
    logic [31:0] step_div;
    logic [8:0]  fault_count;

    // ********************************************************
    // decode
    // ********************************************************
    logic        wr_out;
    logic        wr_volt;
    logic        wr_curr;
    logic        wr_pend;
    logic        wr_ceil;
    logic        wr_thresh;
    logic        wr_delay;
    logic        wr_cmd;
    logic        wr_loc;
    logic        cmd_trigger;
    logic        cmd_oc_clear;
    logic        cmd_ov_clear;
    logic        cmd_run;
    logic        cmd_stop;
    logic        cmd_dev_reset;
    logic        cmd_meas_args;
    logic [15:0] wval;

    assign wval          = WDATA[15:0];
    assign wr_out        = WR && (ADDR == OUTPUT_STATE_ADDR);
    assign wr_volt       = WR && (ADDR == VOLT_SET_ADDR);
    assign wr_curr       = WR && (ADDR == CURR_SET_ADDR);
    assign wr_pend       = WR && (ADDR == PENDING_CURR_ADDR);
    assign wr_ceil       = WR && (ADDR == CEILING_ADDR);
    assign wr_thresh     = WR && (ADDR == OC_THRESH_ADDR);
    assign wr_delay      = WR && (ADDR == TRIP_DELAY_ADDR);
    assign wr_cmd        = WR && (ADDR == COMMAND_ADDR);
    assign wr_loc        = WR && (ADDR == SEQ_START_ADDR);
    assign cmd_trigger   = wr_cmd && WDATA[CMD_TRIGGER];
    assign cmd_oc_clear  = wr_cmd && WDATA[CMD_OC_CLEAR];
    assign cmd_ov_clear  = wr_cmd && WDATA[CMD_OV_CLEAR];
    assign cmd_run       = wr_cmd && WDATA[CMD_RUN];
    assign cmd_stop      = wr_cmd && WDATA[CMD_STOP];
    assign cmd_dev_reset = wr_cmd && WDATA[CMD_DEV_RESET];
    assign cmd_meas_args = wr_cmd && WDATA[CMD_MEAS_ARGS];

    // ********************************************************
    // range checks on written values
    // ********************************************************
    logic curr_over_max;
    logic curr_over_ceil;
    logic pend_over_max;
    logic pend_over_ceil;
    logic volt_bad;
    logic ceil_bad;
    logic thresh_bad;
    logic delay_bad;
    logic loc_bad;

    assign curr_over_max  = wval > MODEL_MAX_CURR;
    assign curr_over_ceil = wval > current_ceiling;
    assign pend_over_max  = wval > MODEL_MAX_CURR;
    assign pend_over_ceil = wval > current_ceiling;
    assign volt_bad       = wval > MODEL_MAX_VOLT;
    assign ceil_bad       = wval > MODEL_MAX_CURR;
    assign thresh_bad     = wval > MODEL_MAX_CURR;
    assign delay_bad      = WDATA[15:0] > 16'(MAX_DELAY_COUNT);
    assign loc_bad        = (WDATA[15:0] < 16'(SEQ_LOC_MIN)) ||
                            (WDATA[15:0] > 16'(SEQ_LOC_MAX));

    // ********************************************************
    // protection delay
    // ********************************************************
    logic oc_fault;
    logic any_fault;
    logic step_tick;
    logic delay_done;
    logic trip_now;

    // threshold compares against measured current, not the setpoint
    assign oc_fault   = MEAS_CURRENT > overcurrent_threshold;
    assign any_fault  = oc_fault || OV_DETECT;
    assign step_tick  = step_div == 32'(DELAY_STEP_CYCLES - 1);
    assign delay_done = fault_count >= protection_trip_delay;
    assign trip_now   = any_fault && delay_done;

    // step divider runs only during a fault so each count is a full step
    always_ff @(posedge CLK) begin
        if (SYS_RST || !any_fault || step_tick) begin
            step_div <= 32'h0000_0000;
        end else begin
            step_div <= step_div + 32'h0000_0001;
        end
    end

    // counts whole steps of continuous fault; restarts when it clears
    always_ff @(posedge CLK) begin
        if (SYS_RST || !any_fault) begin
            fault_count <= 9'h000;
        end else if (step_tick && !delay_done) begin
            fault_count <= fault_count + 9'h001;
        end
    end

    // trip flags; a trip in the clear cycle wins over the clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            oc_tripped <= 1'b0;
            ov_tripped <= 1'b0;
        end else begin
            if (trip_now && oc_fault) begin
                oc_tripped <= 1'b1;
            end else if (cmd_oc_clear) begin
                oc_tripped <= 1'b0;
            end
            if (trip_now && OV_DETECT) begin
                ov_tripped <= 1'b1;
            end else if (cmd_ov_clear) begin
                ov_tripped <= 1'b0;
            end
        end
    end

    // ********************************************************
    // output state and setpoints
    // ********************************************************
    // output on at power up; off keeps setpoints, applied path zeroes
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            output_on <= 1'b1;
        end else if (wr_out) begin
            output_on <= WDATA[0];
        end
    end

    // voltage setpoint, forced to zero by an overcurrent clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            volt_set <= RESET_VOLT;
        end else if (cmd_oc_clear) begin
            volt_set <= 16'h0000;
        end else if (wr_volt && !volt_bad) begin
            volt_set <= wval;
        end
    end

    // current setpoint: reject, clamp, trigger or clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            curr_set <= RESET_CURR;
        end else if (cmd_oc_clear) begin
            curr_set <= CLEAR_CURR;
        end else if (wr_curr && !curr_over_max) begin
            curr_set <= curr_over_ceil ? current_ceiling : wval;
        end else if (cmd_trigger) begin
            curr_set <= pending_current_value;
        end
    end

    // pending current is held apart until a trigger moves it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pending_current_value <= RESET_CURR;
        end else if (wr_pend && !pend_over_max) begin
            pending_current_value <= pend_over_ceil ? current_ceiling
                                                    : wval;
        end
    end

    // ceiling and threshold are range-checked, rejects keep old value
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            current_ceiling       <= MODEL_MAX_CURR;
            overcurrent_threshold <= MODEL_MAX_CURR;
        end else begin
            if (wr_ceil && !ceil_bad) begin
                current_ceiling <= wval;
            end
            if (wr_thresh && !thresh_bad) begin
                overcurrent_threshold <= wval;
            end
        end
    end

    // delay stored as integer step count, read back as stored
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            protection_trip_delay <= RESET_DELAY;
        end else if (wr_delay && !delay_bad) begin
            protection_trip_delay <= WDATA[8:0];
        end
    end

    // ********************************************************
    // stored sequence
    // ********************************************************
    // start location only changes when valid
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sequence_start_location <= RESET_SEQ_LOC;
        end else if (wr_loc && !loc_bad) begin
            sequence_start_location <= WDATA[5:0];
        end
    end

    // run state; stop, device reset or sequencer end all halt it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sequence_run_control <= 1'b0;
        end else if (cmd_stop || cmd_dev_reset) begin
            sequence_run_control <= 1'b0;
        end else if (cmd_run) begin
            sequence_run_control <= 1'b1;
        end else if (SEQ_DONE) begin
            sequence_run_control <= 1'b0;
        end
    end

    // ********************************************************
    // warning flag and error queue
    // ********************************************************
    logic rd_question;
    logic rd_error;
    logic new_error;
    logic [15:0] new_code;

    assign rd_question = RD && (ADDR == QUESTION_ADDR);
    assign rd_error    = RD && (ADDR == ERROR_ADDR);

    // the queue holds the latest error; range errors outrank clamps
    always_comb begin
        new_error = 1'b1;
        new_code  = ERR_RANGE;
        if ((wr_curr && curr_over_max) || (wr_pend && pend_over_max) ||
            (wr_volt && volt_bad) || (wr_ceil && ceil_bad) ||
            (wr_thresh && thresh_bad) || (wr_delay && delay_bad) ||
            (wr_loc && loc_bad)) begin
            new_code = ERR_RANGE;
        end else if (wr_curr && curr_over_ceil) begin
            new_code = ERR_LIMIT;
        end else begin
            new_error = 1'b0;
        end
    end

    // reading the queue empties it; a new error in that cycle is kept
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            error_code <= ERR_NONE;
        end else if (new_error) begin
            error_code <= new_code;
        end else if (rd_error) begin
            error_code <= ERR_NONE;
        end
    end

    // warning is an event bit cleared by reading, set wins
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cmd_warn <= 1'b0;
        end else if (cmd_meas_args) begin
            cmd_warn <= 1'b1;
        end else if (rd_question) begin
            cmd_warn <= 1'b0;
        end
    end

    // ********************************************************
    // read port
    // ********************************************************
    logic [31:0] next_rdata;

    // setpoint reads show stored values even while output is off
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (ADDR)
            OUTPUT_STATE_ADDR: next_rdata = {31'h0, output_on};
            VOLT_SET_ADDR:     next_rdata = {16'h0, volt_set};
            CURR_SET_ADDR:     next_rdata = {16'h0, curr_set};
            PENDING_CURR_ADDR: next_rdata = {16'h0, pending_current_value};
            CEILING_ADDR:      next_rdata = {16'h0, current_ceiling};
            OC_THRESH_ADDR:    next_rdata = {16'h0, overcurrent_threshold};
            TRIP_DELAY_ADDR:   next_rdata = {23'h0, protection_trip_delay};
            STATUS_ADDR:       next_rdata = {29'h0, ov_tripped,
                                             sequence_run_control,
                                             oc_tripped};
            QUESTION_ADDR: begin
                next_rdata[Q_WARN_BIT] = cmd_warn;
                next_rdata[Q_OC_BIT]   = oc_tripped;
                next_rdata[Q_OV_BIT]   = ov_tripped;
            end
            ERROR_ADDR:        next_rdata = {16'h0, error_code};
            SEQ_START_ADDR:    next_rdata = {26'h0, sequence_start_location};
            CURR_MAX_ADDR: next_rdata = {16'h0, MODEL_MAX_CURR};
            CURR_MIN_ADDR:     next_rdata = 32'h0000_0000;
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (SYS_RST || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ********************************************************
    // applied output
    // ********************************************************
    logic out_live;

    // trip or off zeroes the applied values but never the setpoints
    assign out_live = output_on && !oc_tripped && !ov_tripped;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            OUTPUT_ENABLE <= 1'b0;
            APPLIED_VOLT  <= 16'h0000;
            APPLIED_CURR  <= 16'h0000;
        end else begin
            OUTPUT_ENABLE <= out_live;
            APPLIED_VOLT  <= out_live ? volt_set : 16'h0000;
            APPLIED_CURR  <= out_live ? curr_set : 16'h0000;
        end
    end

    // sequence outputs: keypad locked for as long as the run lasts
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SEQ_RUN       <= 1'b0;
            KEYPAD_LOCK   <= 1'b0;
            SEQ_START_LOC <= RESET_SEQ_LOC;
        end else begin
            SEQ_RUN       <= sequence_run_control;
            KEYPAD_LOCK   <= sequence_run_control;
            SEQ_START_LOC <= sequence_start_location;
        end
    end

endmodule

//--- supply_ctrl_chk.sv
// concurrent checks on the supply output controller ports
`timescale 1ns/1ns
module supply_ctrl_chk
    import supply_ctrl_pkg::*;
#(
    parameter int DELAY_STEP_CYCLES = STEP_CYCLES
) (
    // clock, reset and register port
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // load and sequencer side
    input wire logic [15:0] MEAS_CURRENT,
    input wire logic        OV_DETECT,
    input wire logic        SEQ_DONE,
    input wire logic        SEQ_RUN,
    input wire logic [5:0]  SEQ_START_LOC,
    input wire logic        KEYPAD_LOCK,
    input wire logic        OUTPUT_ENABLE,
    input wire logic [15:0] APPLIED_VOLT,
    input wire logic [15:0] APPLIED_CURR
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire cmd_wr = WR && ADDR == COMMAND_ADDR;
    sequence s_run;
        cmd_wr && WDATA[CMD_RUN] && !WDATA[CMD_STOP]
        && !WDATA[CMD_DEV_RESET] && !SEQ_DONE;
    endsequence
    sequence s_halt;
        cmd_wr && (WDATA[CMD_STOP] || WDATA[CMD_DEV_RESET]);
    endsequence
    property p_run; s_run ##1 !SEQ_DONE |-> ##1 SEQ_RUN; endproperty
    property p_halt;
        s_halt ##1 !(cmd_wr && WDATA[CMD_RUN]) |-> ##1 !SEQ_RUN;
    endproperty
    property p_lock; KEYPAD_LOCK == SEQ_RUN; endproperty
    property p_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
    property p_dead;
        !OUTPUT_ENABLE |-> APPLIED_VOLT == 16'h0 && APPLIED_CURR == 16'h0;
    endproperty
    property p_cap; APPLIED_CURR <= MODEL_MAX_CURR; endproperty
    property p_loc;
        SEQ_START_LOC >= SEQ_LOC_MIN && SEQ_START_LOC <= SEQ_LOC_MAX;
    endproperty
    property p_off;
        WR && ADDR == OUTPUT_STATE_ADDR && !WDATA[0]
        |=> ##1 !OUTPUT_ENABLE && APPLIED_CURR == 16'h0;
    endproperty
    property p_max;
        RD && ADDR == CURR_MAX_ADDR |=> RDATA == {16'h0, MODEL_MAX_CURR};
    endproperty
    property p_min; RD && ADDR == CURR_MIN_ADDR |=> RDATA == 32'h0; endproperty
    a_run: assert property (p_run) else $error("run not seen");
    a_halt: assert property (p_halt) else $error("halt missed");
    a_lock: assert property (p_lock) else $error("keypad lock");
    a_idle: assert property (p_idle) else $error("rdata not 0");
    a_dead: assert property (p_dead) else $error("dead output");
    a_cap: assert property (p_cap) else $error("curr > max");
    a_loc: assert property (p_loc) else $error("start loc");
    a_off: assert property (p_off) else $error("off not zero");
    a_max: assert property (p_max) else $error("max read");
    a_min: assert property (p_min) else $error("min read");
endmodule

bind supply_ctrl supply_ctrl_chk #(.DELAY_STEP_CYCLES(DELAY_STEP_CYCLES))
    chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MEAS_CURRENT(MEAS_CURRENT),
    .OV_DETECT(OV_DETECT), .SEQ_DONE(SEQ_DONE), .SEQ_RUN(SEQ_RUN),
    .SEQ_START_LOC(SEQ_START_LOC), .KEYPAD_LOCK(KEYPAD_LOCK),
    .OUTPUT_ENABLE(OUTPUT_ENABLE), .APPLIED_VOLT(APPLIED_VOLT),
    .APPLIED_CURR(APPLIED_CURR));

//--- supply_ctrl_pkg.sv
// constants, register map and command codes of the supply output controller
package supply_ctrl_pkg;

    // ********************************************************
    // register offsets (byte addresses)
    // ********************************************************
    localparam logic [7:0] OUTPUT_STATE_ADDR = 8'h00;
    localparam logic [7:0] VOLT_SET_ADDR     = 8'h04;
    localparam logic [7:0] CURR_SET_ADDR     = 8'h08;
    localparam logic [7:0] PENDING_CURR_ADDR = 8'h0c;
    localparam logic [7:0] CEILING_ADDR      = 8'h10;
    localparam logic [7:0] OC_THRESH_ADDR    = 8'h14;
    localparam logic [7:0] TRIP_DELAY_ADDR   = 8'h18;
    localparam logic [7:0] COMMAND_ADDR      = 8'h1c;
    localparam logic [7:0] STATUS_ADDR       = 8'h20;
    localparam logic [7:0] QUESTION_ADDR     = 8'h24;
    localparam logic [7:0] ERROR_ADDR        = 8'h28;
    localparam logic [7:0] SEQ_START_ADDR    = 8'h2c;
    localparam logic [7:0] CURR_MAX_ADDR     = 8'h30;
    localparam logic [7:0] CURR_MIN_ADDR     = 8'h34;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int CMD_TRIGGER   = 0;
    localparam int CMD_OC_CLEAR  = 1;
    localparam int CMD_RUN       = 2;
    localparam int CMD_STOP      = 3;
    localparam int CMD_DEV_RESET = 4;
    localparam int CMD_MEAS_ARGS = 5;
    localparam int CMD_OV_CLEAR  = 6;
    localparam int Q_OV_BIT      = 0;
    localparam int Q_OC_BIT      = 1;
    localparam int Q_WARN_BIT    = 13;

    // ********************************************************
    // model limits, values in mV and mA, reset values
    // ********************************************************
    localparam logic [15:0] MODEL_MAX_VOLT = 16'h61a8;
    localparam logic [15:0] MODEL_MAX_CURR = 16'h0fa0;
    localparam logic [15:0] CLEAR_CURR     = MODEL_MAX_CURR / 16'h0064;
    localparam logic [15:0] RESET_VOLT     = 16'h0000;
    localparam logic [15:0] RESET_CURR     = 16'h0000;
    localparam logic [5:0]  SEQ_LOC_MIN    = 6'h01;
    localparam logic [5:0]  SEQ_LOC_MAX    = 6'h28;
    localparam logic [5:0]  RESET_SEQ_LOC  = 6'h01;
    localparam logic [15:0] ERR_NONE       = 16'h0000;
    localparam logic [15:0] ERR_RANGE      = 16'hff22; // -222
    localparam logic [15:0] ERR_LIMIT      = 16'hfed3; // -301

    // ********************************************************
    // protection delay timing
    // ********************************************************
    localparam int CLK_HZ           = 100_000_000;
    localparam int DELAY_STEP_US    = 33_000;     // 0.033 s per count
    localparam int MAX_DELAY_US     = 8_500_000;  // 8.50 s
    localparam int STEP_CYCLES      = DELAY_STEP_US * (CLK_HZ / 1_000_000);
    localparam logic [8:0] MAX_DELAY_COUNT =
        9'(MAX_DELAY_US / DELAY_STEP_US);
    localparam logic [8:0] RESET_DELAY = 9'h000;

endpackage

//--- supply_load_model.sv
// load and sequencer model on the far side of the controller
`timescale 1ns/1ns
module supply_load_model (
    // controls from the controller and the bench
    input  wire logic        clk,
    input  wire logic        output_enable,
    input  wire logic        seq_run,
    input  wire logic [15:0] load_ma,
    input  wire logic        ov_req,
    // measured values back to the controller
    output logic      [15:0] meas_current,
    output logic             ov_detect,
    output logic             seq_done
);
    // ****************************************
    // behaviour
    // ****************************************
    logic [5:0] steps;
    // a dead output draws nothing and cannot overvolt, so a trip
    // removes its own fault
    always_ff @(posedge clk) begin
        meas_current <= output_enable ? load_ma : 16'h0000;
        ov_detect    <= output_enable && ov_req;
    end
    // the stored sequence ends by itself after 30 cycles
    always_ff @(posedge clk) begin
        steps    <= seq_run ? steps + 6'h01 : 6'h00;
        seq_done <= seq_run && steps == 6'h1e;
    end
endmodule

//--- supply_output_command_control_tb_top.sv
// self-checking bench for the supply output controller
`timescale 1ns/1ns
module supply_output_command_control_tb_top;
    import supply_ctrl_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        CLK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [15:0] MEAS_CURRENT, APPLIED_VOLT, APPLIED_CURR;
    logic [15:0] load_ma = 16'h0000;
    logic        ov_on = 1'b0;
    logic [5:0]  SEQ_START_LOC;
    logic        OV_DETECT, SEQ_DONE, SEQ_RUN, KEYPAD_LOCK, OUTPUT_ENABLE;
    int          err_count = 0, cmp_count = 0;
    supply_ctrl #(.DELAY_STEP_CYCLES(4)) dut_u (.CLK(CLK),
        .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .MEAS_CURRENT(MEAS_CURRENT), .OV_DETECT(OV_DETECT),
        .SEQ_DONE(SEQ_DONE), .SEQ_RUN(SEQ_RUN),
        .SEQ_START_LOC(SEQ_START_LOC), .KEYPAD_LOCK(KEYPAD_LOCK),
        .OUTPUT_ENABLE(OUTPUT_ENABLE), .APPLIED_VOLT(APPLIED_VOLT),
        .APPLIED_CURR(APPLIED_CURR));
    supply_load_model load_u (.clk(CLK), .output_enable(OUTPUT_ENABLE),
        .seq_run(SEQ_RUN), .load_ma(load_ma), .meas_current(MEAS_CURRENT),
        .ov_req(ov_on), .ov_detect(OV_DETECT), .seq_done(SEQ_DONE));
    // 100 MHz clock
    initial begin
        forever #5 CLK = ~CLK;
    end
    // ****************************************
    // tasks
    // ****************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // read data are only valid in the one cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        chk($sformatf("rd %h", a), e, RDATA);
    endtask
    task settle;
        repeat (2) @(negedge CLK);
    endtask
    task load(input logic [15:0] ma, input int n);
        @(posedge CLK);
        load_ma <= ma;
        repeat (n) @(posedge CLK);
    endtask
    task summarize;
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        summarize();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(OUTPUT_STATE_ADDR, 32'h1);
        rd(CURR_MAX_ADDR, 32'h0fa0);
        rd(CURR_MIN_ADDR, 32'h0);
        rd(8'h3c, 32'h0);
        wr(CURR_SET_ADDR, 32'h64);
        rd(CURR_SET_ADDR, 32'h64);
        wr(CEILING_ADDR, 32'h0ce4);
        wr(CURR_SET_ADDR, 32'h1068);
        rd(CURR_SET_ADDR, 32'h64);
        rd(ERROR_ADDR, 32'hff22);
        wr(CURR_SET_ADDR, 32'h0dac);
        rd(CURR_SET_ADDR, 32'h0ce4);
        rd(ERROR_ADDR, 32'hfed3);
        wr(VOLT_SET_ADDR, 32'h5208);
        wr(OUTPUT_STATE_ADDR, 32'h0);
        settle();
        chk("volt off", 32'h0, 32'(APPLIED_VOLT));
        rd(OUTPUT_STATE_ADDR, 32'h0);
        rd(VOLT_SET_ADDR, 32'h5208);
        rd(CURR_SET_ADDR, 32'h0ce4);
        wr(OUTPUT_STATE_ADDR, 32'h1);
        settle();
        chk("volt on", 32'h5208, 32'(APPLIED_VOLT));
        chk("curr on", 32'h0ce4, 32'(APPLIED_CURR));
        wr(CURR_SET_ADDR, 32'hc8);
        wr(PENDING_CURR_ADDR, 32'h1388);
        rd(ERROR_ADDR, 32'hff22);
        wr(PENDING_CURR_ADDR, 32'h05dc);
        rd(CURR_SET_ADDR, 32'hc8);
        wr(COMMAND_ADDR, 32'h1 << CMD_TRIGGER);
        rd(CURR_SET_ADDR, 32'h05dc);
        wr(COMMAND_ADDR, 32'h1 << CMD_MEAS_ARGS);
        rd(QUESTION_ADDR, 32'h2000);
        wr(TRIP_DELAY_ADDR, 32'h101);
        wr(TRIP_DELAY_ADDR, 32'h102);
        rd(TRIP_DELAY_ADDR, 32'h101);
        wr(TRIP_DELAY_ADDR, 32'h3);
        wr(OC_THRESH_ADDR, 32'h03e8);
        rd(OC_THRESH_ADDR, 32'h03e8);
        load(16'h04b0, 8);
        load(16'h0, 2);
        load(16'h04b0, 8);
        load(16'h0, 2);
        rd(STATUS_ADDR, 32'h0);
        load(16'h04b0, 20);
        load(16'h0, 2);
        rd(STATUS_ADDR, 32'h1);
        chk("enable", 32'h0, 32'(OUTPUT_ENABLE));
        rd(QUESTION_ADDR, 32'h2);
        wr(COMMAND_ADDR, 32'h1 << CMD_OC_CLEAR);
        rd(STATUS_ADDR, 32'h0);
        rd(CURR_SET_ADDR, 32'h28);
        rd(VOLT_SET_ADDR, 32'h0);
        wr(TRIP_DELAY_ADDR, 32'h0);
        load(16'h04b0, 1);
        load(16'h0, 3);
        rd(STATUS_ADDR, 32'h1);
        wr(COMMAND_ADDR, 32'h1 << CMD_OC_CLEAR);
        @(posedge CLK);
        ov_on <= 1'b1;
        repeat (4) @(posedge CLK);
        ov_on <= 1'b0;
        rd(STATUS_ADDR, 32'h4);
        rd(QUESTION_ADDR, 32'h1);
        wr(COMMAND_ADDR, 32'h1 << CMD_OV_CLEAR);
        rd(STATUS_ADDR, 32'h0);
        wr(SEQ_START_ADDR, 32'h15);
        wr(SEQ_START_ADDR, 32'h29);
        rd(SEQ_START_ADDR, 32'h15);
        wr(COMMAND_ADDR, 32'h1 << CMD_RUN);
        settle();
        chk("start loc", 32'h15, 32'(SEQ_START_LOC));
        chk("lock", 32'h1, 32'(KEYPAD_LOCK));
        rd(STATUS_ADDR, 32'h2);
        wr(COMMAND_ADDR, 32'h1 << CMD_STOP);
        rd(STATUS_ADDR, 32'h0);
        wr(COMMAND_ADDR, 32'h1 << CMD_RUN);
        wr(COMMAND_ADDR, 32'h1 << CMD_DEV_RESET);
        settle();
        chk("abort", 32'h0, 32'(SEQ_RUN));
        wr(COMMAND_ADDR, 32'h1 << CMD_RUN);
        repeat (40) @(posedge CLK);
        rd(STATUS_ADDR, 32'h0);
        summarize();
    end
endmodule
